// ==== pkg/csao_pkg.sv ====
// Function
// - adjust adds 6 to W when low nibble > 9 or digit carry; carry updated.
// - decrement takes one from f and updates all five flags in one cycle.
// - destination bit 0 writes the result to W, 1 back to the file register.
// - access bit 0 picks the access bank, 1 the bank select register.
// - extended set, access bit 0 and f up to 95 mean indexed literal offset.
// - decrement-skip writes the result, skips on non-zero, flags unchanged.
// - increment-skip writes the result, skips on non-zero, or on zero in its skip-if-zero form; flags unchanged.
// - a taken skip drops the fetched word and runs one no-operation cycle.
// - skipping a two-word instruction takes two no-operation cycles.
// - OR-literal ORs the immediate into W and updates N and Z in one cycle.
// - pointer load: high nibble in the first cycle, low byte in the second.
package csao_pkg;
    localparam logic [15:0] OP_DADJ_CODE  = 16'h0007;
    localparam logic [5:0]  OP_DEC_CODE   = 6'h01;
    localparam logic [5:0]  OP_DCSNZ_CODE = 6'h13;
    localparam logic [5:0]  OP_INSNZ_CODE = 6'h12;
    localparam logic [5:0]  OP_INSZ_CODE  = 6'h0f;
    localparam logic [6:0]  OP_CPEQ_CODE  = 7'h31;
    localparam logic [6:0]  OP_CPLT_CODE  = 7'h30;
    localparam logic [7:0]  OP_IOR_CODE   = 8'h09;
    localparam logic [9:0]  OP_LFP_CODE   = 10'h3b8;
    localparam logic [3:0]  OP_LFP2_CODE  = 4'hf;
    localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
    localparam logic [3:0]  BCD_LIMIT     = 4'h9;
    localparam logic [3:0]  BCD_FIX       = 4'h6;
    localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
    localparam logic [7:0]  ACC_SPLIT     = 8'h60;
    localparam logic [7:0]  W_RST         = 8'h00;
    localparam logic [4:0]  FLAG_RST      = 5'h00;
    localparam logic [11:0] PTR_RST       = 12'h000;
    localparam int          FLAG_C        = 0;
    localparam int          FLAG_DGC      = 1;
    localparam int          FLAG_Z        = 2;
    localparam int          FLAG_OVF      = 3;
    localparam int          FLAG_N        = 4;

    typedef enum logic [2:0] {
        CSAO_EXEC = 3'b001,
        CSAO_NOP1 = 3'b010,
        CSAO_LFP2 = 3'b100
    } csao_state_e;

    // one file register access toward the data memory
    typedef struct packed {
        logic        wr;
        logic        idx;
        logic [11:0] addr;
        logic [7:0]  data;
    } csao_fwr_s;
endpackage : csao_pkg

// ==== hw/csao_ptr.sv ====
module csao_ptr
    import csao_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // load strobes
    input  wire logic        ld_hi_i,
    input  wire logic        ld_lo_i,
    input  wire logic [3:0]  hi_i,
    input  wire logic [7:0]  lo_i,
    // pointer value
    output logic      [11:0] ptr_o
);
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_o <= PTR_RST;
        end else begin
            if (ld_hi_i) ptr_o[11:8] <= hi_i;
            if (ld_lo_i) ptr_o[7:0] <= lo_i;
        end
    end
endmodule : csao_ptr

// ==== hw/csao_core.sv ====
module csao_core
    import csao_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // instruction stream
    input  wire logic        instr_vld_i,
    input  wire logic [15:0] instr_i,
    input  wire logic        next_two_word_i,
    input  wire logic        ext_set_en_i,
    // context
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic [7:0]  file_rd_data_i,
    // file register side
    output logic      [11:0] file_rd_addr_o,
    output logic             file_rd_idx_o,
    output csao_fwr_s        file_wr_o,
    // core state
    output logic      [7:0]  w_o,
    output logic      [4:0]  status_o,
    output logic             busy_o,
    output logic             skip_o,
    output logic      [11:0] file_select_pointer0_o,
    output logic      [11:0] file_select_pointer1_o,
    output logic      [11:0] file_select_pointer2_o
);
    csao_state_e state_r, state_nxt;
    logic [7:0]  w_r, w_nxt;
    logic [4:0]  flag_r, flag_nxt;
    logic        nop2_r, nop2_nxt;
    logic [1:0]  psel_r;
    csao_fwr_s   fwr_r, fwr_nxt;
    logic        skip_r;

    // decode
    wire logic       exec     = instr_vld_i && (state_r == CSAO_EXEC);
    wire logic [7:0] fa       = instr_i[7:0];
    wire logic       d_bit    = instr_i[9];
    wire logic       a_bit    = instr_i[8];
    wire logic       is_dadj  = exec && (instr_i == OP_DADJ_CODE);
    wire logic       is_dec   = exec && (instr_i[15:10] == OP_DEC_CODE);
    wire logic       is_dcsnz = exec && (instr_i[15:10] == OP_DCSNZ_CODE);
    wire logic       is_insnz = exec && (instr_i[15:10] == OP_INSNZ_CODE);
    wire logic       is_insz  = exec && (instr_i[15:10] == OP_INSZ_CODE);
    wire logic       is_cpeq  = exec && (instr_i[15:9] == OP_CPEQ_CODE);
    wire logic       is_cplt  = exec && (instr_i[15:9] == OP_CPLT_CODE);
    wire logic       is_ior   = exec && (instr_i[15:8] == OP_IOR_CODE);
    wire logic       is_lfp   = exec && (instr_i[15:6] == OP_LFP_CODE);
    wire logic       lfp_lo   = instr_vld_i && (state_r == CSAO_LFP2)
                                && (instr_i[15:12] == OP_LFP2_CODE);

    // addressing
    wire logic       idx_mode = ext_set_en_i && !a_bit
                                && (fa <= IDX_LIMIT);
    wire logic [3:0] acc_bank = (fa < ACC_SPLIT) ? ACC_LOW_BANK
                                                 : ACC_HIGH_BANK;
    wire logic [3:0] bank     = a_bit ? bank_select_register_i
                                      : acc_bank;

    // arithmetic
    wire logic [7:0] f_val    = file_rd_data_i;
    wire logic [8:0] dec_sum  = {1'b0, f_val} + 9'h0ff;        // f + (-1)
    wire logic [7:0] dec_res  = dec_sum[7:0];
    wire logic [7:0] inc_res  = f_val + 8'h01;
    wire logic       dec_dgc  = (f_val[3:0] != 4'h0);
    wire logic       dec_ovf  = (f_val == 8'h80);
    wire logic [7:0] ior_res  = w_r | fa;
    wire logic       lo_fix   = (w_r[3:0] > BCD_LIMIT)
                                || flag_r[FLAG_DGC];
    wire logic [8:0] dadj_sum = {1'b0, w_r}
                                + {5'h00, lo_fix ? BCD_FIX : 4'h0};
    wire logic [7:0] arith    = is_dec ? dec_res
                              : (is_dcsnz ? dec_res : inc_res);
    wire logic       wr_op    = is_dec || is_dcsnz || is_insnz || is_insz;

    // skip decision
    wire logic skip = (is_dcsnz && (dec_res != 8'h00))
                    || (is_insnz && (inc_res != 8'h00))
                    || (is_insz && (inc_res == 8'h00))
                    || (is_cpeq && (f_val == w_r))
                    || (is_cplt && (f_val < w_r));

    assign file_rd_addr_o = {bank, fa};
    assign file_rd_idx_o  = idx_mode;

    always_comb begin
        state_nxt = state_r;
        w_nxt     = w_r;
        flag_nxt  = flag_r;
        nop2_nxt  = nop2_r;
        fwr_nxt   = '0;
        unique case (state_r)
            CSAO_EXEC: begin
                if (wr_op) begin
                    if (d_bit) begin
                        fwr_nxt.wr   = 1'b1;
                        fwr_nxt.idx  = idx_mode;
                        fwr_nxt.addr = {bank, fa};
                        fwr_nxt.data = arith;
                    end else begin
                        w_nxt = arith;
                    end
                end
                if (is_dec) begin
                    flag_nxt[FLAG_C]  = dec_sum[8];
                    flag_nxt[FLAG_DGC] = dec_dgc;
                    flag_nxt[FLAG_N]  = dec_res[7];
                    flag_nxt[FLAG_OVF] = dec_ovf;
                    flag_nxt[FLAG_Z]  = (dec_res == 8'h00);
                end
                if (is_ior) begin
                    w_nxt            = ior_res;
                    flag_nxt[FLAG_N] = ior_res[7];
                    flag_nxt[FLAG_Z] = (ior_res == 8'h00);
                end
                if (is_dadj) begin
                    w_nxt = dadj_sum[7:0];
                    flag_nxt[FLAG_C] = flag_r[FLAG_C] | dadj_sum[8];
                end
                if (skip) begin
                    state_nxt = CSAO_NOP1;
                    nop2_nxt  = next_two_word_i;
                end else if (is_lfp) begin
                    state_nxt = CSAO_LFP2;
                end
            end
            CSAO_NOP1: begin
                // fetched word dropped; second word also dropped when nop2_r is set
                if (nop2_r) begin
                    nop2_nxt = 1'b0;
                end else begin
                    state_nxt = CSAO_EXEC;
                end
            end
            CSAO_LFP2: begin
                // waits for the second word; an idle slot is harmless
                if (lfp_lo) state_nxt = CSAO_EXEC;
            end
            default: begin
                state_nxt = CSAO_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= CSAO_EXEC;
            w_r     <= W_RST;
            flag_r  <= FLAG_RST;
            nop2_r  <= 1'b0;
            fwr_r   <= '0;
            skip_r  <= 1'b0;
            psel_r  <= 2'b00;
        end else begin
            state_r <= state_nxt;
            w_r     <= w_nxt;
            flag_r  <= flag_nxt;
            nop2_r  <= nop2_nxt;
            fwr_r   <= fwr_nxt;
            skip_r  <= skip;
            if (is_lfp) psel_r <= instr_i[5:4];
        end
    end

    // pointer banks, one per selectable pointer
    logic [11:0] ptr_q [3];
    for (genvar g = 0; g < 3; g++) begin : g_ptr
        csao_ptr u_ptr (
            .clk_sys_i (clk_sys_i),
            .arst_n_i  (arst_n_i),
            .ld_hi_i   (is_lfp && (instr_i[5:4] == 2'(g))),
            .ld_lo_i   (lfp_lo && (psel_r == 2'(g))),
            .hi_i      (instr_i[3:0]),
            .lo_i      (instr_i[7:0]),
            .ptr_o     (ptr_q[g])
        );
    end

    assign file_wr_o              = fwr_r;
    assign w_o                    = w_r;
    assign status_o               = flag_r;
    assign busy_o                 = (state_r != CSAO_EXEC);
    assign skip_o                 = skip_r;
    assign file_select_pointer0_o = ptr_q[0];
    assign file_select_pointer1_o = ptr_q[1];
    assign file_select_pointer2_o = ptr_q[2];
endmodule : csao_core

// ==== sim/csao_core_properties.sv ====
module csao_chk
    import csao_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // instruction side
    input  wire logic        instr_vld_i,
    input  wire logic [15:0] instr_i,
    input  wire logic        next_two_word_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic [7:0]  file_rd_data_i,
    // core outputs
    input  wire logic [11:0] file_rd_addr_o,
    input  wire logic        file_rd_idx_o,
    input  wire csao_fwr_s   file_wr_o,
    input  wire logic [7:0]  w_o,
    input  wire logic [4:0]  status_o,
    input  wire logic        busy_o,
    input  wire logic        skip_o,
    input  wire logic [11:0] file_select_pointer0_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    wire logic       go  = instr_vld_i && !busy_o;
    wire logic [7:0] lit = instr_i[7:0];
    wire logic [3:0] khi = instr_i[3:0];
    wire logic       dec = go && instr_i[15:10] == OP_DEC_CODE;
    wire logic       ior = go && instr_i[15:8] == OP_IOR_CODE;
    wire logic       snz = go && (instr_i[15:10] == OP_DCSNZ_CODE
                                  || instr_i[15:10] == OP_INSNZ_CODE);
    // pointer 0 only: one pointer is enough to pin the word order
    wire logic       lp0 = go && instr_i[15:4] == {OP_LFP_CODE, 2'b00};

    a_ior_result: assert property (
        ior |=> w_o == ($past(w_o) | $past(lit))) else $error("or result");
    a_ior_flags: assert property (
        ior |=> status_o[FLAG_Z] == (w_o == 8'h00)
        && status_o[FLAG_N] == w_o[7]) else $error("or flags");
    a_dec_file: assert property (dec && instr_i[9] |=> file_wr_o.wr
        && file_wr_o.data == $past(file_rd_data_i) - 8'h01)
        else $error("dec f");
    a_dec_w: assert property (dec && !instr_i[9] |=> !file_wr_o.wr
        && w_o == $past(file_rd_data_i) - 8'h01) else $error("dec w");
    a_bank_sel: assert property (dec && instr_i[8] |->
        file_rd_addr_o == {bank_select_register_i, lit}) else $error("bank");
    a_idx_mode: assert property (dec && !instr_i[8] |->
        file_rd_idx_o == (ext_set_en_i && lit <= IDX_LIMIT))
        else $error("idx");
    a_skip_flags: assert property (
        snz |=> $stable(status_o)) else $error("skip flags");
    a_skip_nop: assert property (skip_o && !$past(next_two_word_i)
        |-> busy_o ##1 !busy_o) else $error("one nop");
    a_skip_two: assert property (skip_o && $past(next_two_word_i)
        |-> busy_o[*2] ##1 !busy_o) else $error("two nops");
    a_ptr_high: assert property (lp0 |=>
        file_select_pointer0_o[11:8] == $past(khi)) else $error("ptr high");

    c_skip_two: cover property (skip_o && $past(next_two_word_i));
    c_dec_file: cover property (dec && instr_i[9]);
    c_ptr_load: cover property (lp0);
endmodule : csao_chk

bind csao_core csao_chk u_chk (
    .clk_sys_i              (clk_sys_i),
    .arst_n_i               (arst_n_i),
    .instr_vld_i            (instr_vld_i),
    .instr_i                (instr_i),
    .next_two_word_i        (next_two_word_i),
    .ext_set_en_i           (ext_set_en_i),
    .bank_select_register_i (bank_select_register_i),
    .file_rd_data_i         (file_rd_data_i),
    .file_rd_addr_o         (file_rd_addr_o),
    .file_rd_idx_o          (file_rd_idx_o),
    .file_wr_o              (file_wr_o),
    .w_o                    (w_o),
    .status_o               (status_o),
    .busy_o                 (busy_o),
    .skip_o                 (skip_o),
    .file_select_pointer0_o (file_select_pointer0_o)
);

// ==== sim/tb_top.sv ====
module tb_top import csao_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i = 0, arst_n_i = 0, instr_vld_i = 0;
    logic        next_two_word_i = 0, ext_set_en_i = 0;
    logic [15:0] instr_i = 16'h0000;
    logic [3:0]  bank_select_register_i = 4'h5;
    logic [7:0]  file_rd_data_i = 8'h00, w_o;
    logic [11:0] file_rd_addr_o, file_select_pointer0_o;
    logic [11:0] file_select_pointer1_o, file_select_pointer2_o;
    logic [35:0] ptrs;
    logic        file_rd_idx_o, busy_o, skip_o;
    logic [4:0]  status_o;
    csao_fwr_s   file_wr_o;
    int          mismatches = 0, tests_run = 0;

    csao_core u_dut (
        .clk_sys_i              (clk_sys_i),
        .arst_n_i               (arst_n_i),
        .instr_vld_i            (instr_vld_i),
        .instr_i                (instr_i),
        .next_two_word_i        (next_two_word_i),
        .ext_set_en_i           (ext_set_en_i),
        .bank_select_register_i (bank_select_register_i),
        .file_rd_data_i         (file_rd_data_i),
        .file_rd_addr_o         (file_rd_addr_o),
        .file_rd_idx_o          (file_rd_idx_o),
        .file_wr_o              (file_wr_o),
        .w_o                    (w_o),
        .status_o               (status_o),
        .busy_o                 (busy_o),
        .skip_o                 (skip_o),
        .file_select_pointer0_o (file_select_pointer0_o),
        .file_select_pointer1_o (file_select_pointer1_o),
        .file_select_pointer2_o (file_select_pointer2_o)
    );
    assign ptrs = {file_select_pointer2_o, file_select_pointer1_o,
                   file_select_pointer0_o};
    initial forever #20 clk_sys_i = ~clk_sys_i;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // result registers update on the taking edge and are read 1 ns after it
    task op(input logic [15:0] ins, input logic [7:0] rd, input logic two);
        @(posedge clk_sys_i);
        instr_vld_i     <= 1'b1;
        instr_i         <= ins;
        file_rd_data_i  <= rd;
        next_two_word_i <= two;
        @(posedge clk_sys_i);
        instr_vld_i <= 1'b0;
        #1;
    endtask : op

    task t_alu;
        op(16'h0980, 8'h00, 1'b0);
        chk(w_o, 16'h0080);
        chk(status_o, 16'h0010);
        op(16'h097a, 8'h00, 1'b0);
        op(16'h0007, 8'h00, 1'b0);
        chk({w_o, 3'h0, status_o}, 16'h0011);
        op(16'h0900, 8'h00, 1'b0);
        chk(status_o, 16'h0005);
        op(16'h090a, 8'h00, 1'b0);
        op(16'h0007, 8'h00, 1'b0);
        chk(w_o, 16'h0010);
        $display("alu test done");
    endtask : t_alu

    task t_dec;
        op(16'h0734, 8'h10, 1'b0);
        chk({file_wr_o.wr, 3'h0, file_wr_o.addr}, 16'h8534);
        chk({file_wr_o.data, 3'h0, status_o}, 16'h0f01);
        op(16'h0420, 8'h01, 1'b0);
        chk({w_o, 2'h0, file_wr_o.wr, status_o}, 16'h0007);
        // digit carry alone must trigger the adjust
        op(16'h0007, 8'h00, 1'b0);
        chk({w_o, 3'h0, status_o}, 16'h0607);
        op(16'h0420, 8'h01, 1'b0);
        @(posedge clk_sys_i) ext_set_en_i <= 1'b1;
        op(16'h065f, 8'h80, 1'b0);
        chk({file_wr_o.idx, status_o}, 16'h0029);
        chk({4'h0, file_wr_o.addr}, 16'h005f);
        op(16'h0660, 8'h00, 1'b0);
        chk({file_wr_o.idx, status_o}, 16'h0010);
        chk({4'h0, file_wr_o.addr}, 16'h0f60);
        $display("dec test done");
    endtask : t_dec

    task skip_case(input logic [15:0] ins, input logic [7:0] rd,
                   input logic two, input logic sk, input logic [7:0] res);
        logic [4:0] st;
        st = status_o;
        op(ins, rd, two);
        chk({skip_o, busy_o, 3'h0, status_o}, {sk, sk, 3'h0, st});
        if (ins[15:13] != 3'h3) chk(file_wr_o.data, res);
        if (sk && two) begin
            @(posedge clk_sys_i);
            #1;
            chk(busy_o, 16'h0001);
        end
        @(posedge clk_sys_i);
        #1;
        chk(busy_o, 16'h0000);
    endtask : skip_case

    task t_skip;
        op(16'h0940, 8'h00, 1'b0);
        skip_case(16'h4a10, 8'h05, 1'b0, 1'b1, 8'h06);
        skip_case(16'h4a10, 8'hff, 1'b1, 1'b0, 8'h00);
        skip_case(16'h4a10, 8'h05, 1'b1, 1'b1, 8'h06);
        skip_case(16'h4e10, 8'h01, 1'b0, 1'b0, 8'h00);
        skip_case(16'h4e10, 8'h02, 1'b1, 1'b1, 8'h01);
        skip_case(16'h3e10, 8'hff, 1'b0, 1'b1, 8'h00);
        skip_case(16'h3e10, 8'h05, 1'b0, 1'b0, 8'h06);
        skip_case(16'h6210, 8'h40, 1'b0, 1'b1, 8'h00);
        skip_case(16'h6210, 8'h41, 1'b0, 1'b0, 8'h00);
        skip_case(16'h6010, 8'h3f, 1'b0, 1'b1, 8'h00);
        skip_case(16'h6010, 8'hc0, 1'b0, 1'b0, 8'h00);
        $display("skip test done");
    endtask : t_skip

    task t_ptr;
        for (int f = 0; f < 3; f++) begin
            op({10'h3b8, f[1:0], 4'h3}, 8'h00, 1'b0);
            chk({busy_o, 3'h0, ptrs[f*12+8 +: 4]}, 16'h0083);
            op({12'hf0b, 2'h0, f[1:0]}, 8'h00, 1'b0);
            chk(ptrs[f*12 +: 12], {4'h0, 6'h0e, 4'hc, f[1:0]});
        end
        $display("pointer test done");
    endtask : t_ptr

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (8) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_alu;
        t_dec;
        t_skip;
        t_ptr;
        report_and_stop;
    end
endmodule : tb_top
